// *** cio_consts.vh ***
// How it works
// - Block output halves words, or sends whole words when flag set
// - Block output stops when address reaches end address
// - Whole word on 12-bit channel keeps lower half only
// - Idle channel starts block, fetch at P+3; busy fetch at P+2
// - Main control keeps running during block transfer
// - Start address becomes current address as block advances
// - Three-bit channel select picks channel 0 to 7
// - Interrupt flag raises interrupt when transfer finishes
// - Direction flag steps storage address downward
// - Character input clears accumulator, loads low six bits
// - Word input clears accumulator, loads 12 or 24 bits by width
// - Character output sends low six bits, accumulator kept
// - Word output sends 12 or 24 bits by width, accumulator kept
// - Accumulator transfer fetches at P+3 when done, P+2 if busy
// - Mode bit 18 set, bit 20 clear works on both widths
// - Word input assembly: mode 0 forward, mode 2 backward
// - Word output disassembly: mode 2 forward, mode 0 backward
// - Busy while reading, writing, or reply or reject remains
`ifndef CIO_CONSTS_VH
`define CIO_CONSTS_VH
// ====================
// Operations
`define CIO_OP_BLKOUT 3'h0
`define CIO_OP_CHIN 3'h1
`define CIO_OP_WDIN 3'h2
`define CIO_OP_CHOUT 3'h3
`define CIO_OP_WDOUT 3'h4
// ====================
// Bits 18 to 20 codes
`define CIO_MODE_ASM_FWD 3'h0
`define CIO_MODE_ASM_BWD 3'h2
`define CIO_MODE_DIS_FWD 3'h2
`define CIO_MODE_DIS_BWD 3'h0
// ====================
// Output formats
`define CIO_FMT_FULL 2'h0
`define CIO_FMT_HI 2'h1
`define CIO_FMT_LO 2'h2
`define CIO_FMT_CHAR 2'h3
// ====================
// Channel widths, one bit per channel, 1 = 24-bit
`define CIO_WIDE_MASK 8'hF0
// ====================
// Register map
`define CIO_REG_CTRL 8'h00
`define CIO_REG_STATUS 8'h04
`define CIO_REG_CURADDR 8'h08
`define CIO_CTRL_RESET 32'h0000_0001
`define CIO_CTRL_EN_BIT 0
`define CIO_ST_BLK_BIT 0
`define CIO_ST_ACC_BIT 1
`define CIO_ST_CHAN_LSB 2
`define CIO_RESP_OKAY 2'h0
`define CIO_RESP_SLVERR 2'h2
`endif

// *** cio_out_fmt.v ***
`timescale 1ns/10ps
`include "cio_consts.vh"
module cio_out_fmt (
  // Source
  input wire [23:0] word,
  input wire [1:0] fmt,
  input wire wide,
  // Result
  output reg [23:0] data
);
  always @* begin
    case (fmt)
      `CIO_FMT_FULL: data = wide ? word : {12'h000, word[11:0]};
      `CIO_FMT_HI: data = {12'h000, word[23:12]};
      `CIO_FMT_LO: data = {12'h000, word[11:0]};
      `CIO_FMT_CHAR: data = {18'h0_0000, word[5:0]};
      default: data = 24'h00_0000;
    endcase
  end
endmodule

// *** cio_axil_regs.v ***
`timescale 1ns/10ps
`include "cio_consts.vh"
module cio_axil_regs (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Block side
  input wire [31:0] status_word,
  input wire [31:0] curaddr_word,
  output reg [31:0] ctrl_reg
);
  reg aw_got_reg;
  reg w_got_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg w_strb0_reg;
  wire [7:0] ar_word;
  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_word = {s_axi_araddr[7:2], 2'h0};
  // ====================
  // Write path, address and data in either order
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIO_RESP_OKAY;
      ctrl_reg <= `CIO_CTRL_RESET;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (aw_got_reg & w_got_reg & ~s_axi_bvalid) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `CIO_REG_CTRL && w_strb0_reg) begin
          ctrl_reg <= {31'h0000_0000, w_data_reg[`CIO_CTRL_EN_BIT]};
        end
        // Aligned map is contiguous, so anything past the last word is unmapped
        s_axi_bresp <= (aw_addr_reg > `CIO_REG_CURADDR) ? `CIO_RESP_SLVERR : `CIO_RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ====================
  // Read path, one cycle after address
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CIO_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CIO_RESP_OKAY;
      case (ar_word)
        `CIO_REG_CTRL: s_axi_rdata <= ctrl_reg;
        `CIO_REG_STATUS: s_axi_rdata <= status_word;
        `CIO_REG_CURADDR: s_axi_rdata <= curaddr_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CIO_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** cio_unit.v ***
`timescale 1ns/10ps
`include "cio_consts.vh"
module cio_unit (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Instruction issue from main control
  input wire instr_valid,
  output wire instr_ready,
  input wire [2:0] instr_op,
  input wire [2:0] instr_channel_select,
  input wire instr_backward,
  input wire instr_no_assembly,
  input wire instr_interrupt,
  input wire [2:0] instr_mode,
  input wire [16:0] instr_first_addr,
  input wire [16:0] instr_end_addr,
  input wire [23:0] acc_in,
  // Results to main control
  output reg next_instruction_fetch,
  output reg next_fetch_plus3,
  output reg acc_load_valid,
  output reg [23:0] acc_load_data,
  output reg xfer_interrupt,
  // Channel status
  input wire [7:0] chan_rw_active,
  input wire [7:0] chan_reply_pending,
  // Storage read port
  output wire mem_rd_req,
  output wire [16:0] mem_rd_addr,
  input wire mem_rd_ack,
  input wire [23:0] mem_rd_data,
  // Channel output
  output wire ch_out_valid,
  output wire [23:0] ch_out_data,
  output wire [2:0] ch_out_chan,
  input wire ch_out_ready,
  // Channel input
  input wire ch_in_valid,
  input wire [23:0] ch_in_data,
  input wire [2:0] ch_in_chan,
  output wire ch_in_ready,
  // Register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);
  // ====================
  // States
  localparam B_IDLE = 3'h0, B_READ = 3'h1, B_SEND1 = 3'h2, B_SEND2 = 3'h3, B_STEP = 3'h4;
  localparam A_IDLE = 3'h0, A_OUT1 = 3'h1, A_OUT2 = 3'h2, A_IN1 = 3'h3, A_IN2 = 3'h4;
  localparam [7:0] WIDE = `CIO_WIDE_MASK;
  // ====================
  // Declarations
  reg [2:0] blk_state_reg, blk_chan_reg, acc_state_reg, acc_chan_reg, out_chan_reg;
  reg [16:0] blk_addr_reg, blk_end_reg;
  reg [23:0] blk_word_reg, acc_word_reg, out_data_reg;
  reg blk_back_reg, blk_whole_reg, blk_int_reg, acc_char_reg, acc_wide_reg, acc_split_reg, acc_fwd_reg;
  reg acc_int_reg, out_valid_reg, out_owner_blk_reg;
  wire [1:0] blk_fmt, acc_fmt;
  wire [16:0] blk_addr_next;
  wire [31:0] ctrl_reg;
  wire [23:0] blk_fmt_data, acc_fmt_data;
  wire unit_en, sel_busy, accept, blk_sending, acc_sending, grant_blk, grant_acc, out_done;
  wire blk_sent, acc_sent, in_take, sel_wide, blk_wide, blk_irq;
  // ====================
  // Channel selection and busy test
  assign unit_en = ctrl_reg[`CIO_CTRL_EN_BIT];
  assign sel_busy = chan_rw_active[instr_channel_select] | chan_reply_pending[instr_channel_select] |
    (blk_state_reg != B_IDLE && (blk_chan_reg == instr_channel_select || instr_op == `CIO_OP_BLKOUT)) |
    ~unit_en;
  assign sel_wide = WIDE[instr_channel_select];
  assign blk_wide = WIDE[blk_chan_reg];
  // Block runs alone so accumulator work keeps flowing beside it
  assign instr_ready = (acc_state_reg == A_IDLE);
  assign accept = instr_valid & instr_ready;
  // ====================
  // Shared output port, block first
  assign blk_sending = (blk_state_reg == B_SEND1) || (blk_state_reg == B_SEND2);
  assign acc_sending = (acc_state_reg == A_OUT1) || (acc_state_reg == A_OUT2);
  assign grant_blk = ~out_valid_reg & blk_sending;
  assign grant_acc = ~out_valid_reg & ~blk_sending & acc_sending;
  assign out_done = out_valid_reg & ch_out_ready;
  assign blk_sent = out_done & out_owner_blk_reg;
  assign acc_sent = out_done & ~out_owner_blk_reg;
  assign ch_out_valid = out_valid_reg;
  assign ch_out_data = out_data_reg;
  assign ch_out_chan = out_chan_reg;
  assign mem_rd_req = (blk_state_reg == B_READ);
  assign mem_rd_addr = blk_addr_reg;
  assign ch_in_ready = ((acc_state_reg == A_IN1) || (acc_state_reg == A_IN2)) && (ch_in_chan == acc_chan_reg);
  assign in_take = ch_in_valid & ch_in_ready;
  // ====================
  // Output formats
  assign blk_fmt = blk_whole_reg ? `CIO_FMT_FULL :
    ((blk_state_reg == B_SEND1) ^ blk_back_reg) ? `CIO_FMT_HI : `CIO_FMT_LO;
  assign acc_fmt = acc_char_reg ? `CIO_FMT_CHAR :
    !acc_split_reg ? `CIO_FMT_FULL :
    ((acc_state_reg == A_OUT1) ^ ~acc_fwd_reg) ? `CIO_FMT_HI : `CIO_FMT_LO;
  assign blk_addr_next = blk_back_reg ? blk_addr_reg - 17'h0_0001 : blk_addr_reg + 17'h0_0001;
  assign blk_irq = blk_int_reg && blk_state_reg == B_STEP && blk_addr_next == blk_end_reg ||
    instr_interrupt && blk_state_reg == B_IDLE && accept && instr_op == `CIO_OP_BLKOUT && !sel_busy &&
    instr_first_addr == instr_end_addr;
  cio_out_fmt u_blk_fmt (
    .word(blk_word_reg),
    .fmt(blk_fmt),
    .wide(blk_wide),
    .data(blk_fmt_data)
  );
  cio_out_fmt u_acc_fmt (
    .word(acc_word_reg),
    .fmt(acc_fmt),
    .wide(acc_wide_reg),
    .data(acc_fmt_data)
  );
  // ====================
  // Output register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid_reg <= 1'b0;
      out_owner_blk_reg <= 1'b0;
      out_data_reg <= 24'h00_0000;
      out_chan_reg <= 3'h0;
    end else if (out_done) begin
      out_valid_reg <= 1'b0;
    end else if (grant_blk) begin
      out_valid_reg <= 1'b1;
      out_owner_blk_reg <= 1'b1;
      out_data_reg <= blk_fmt_data;
      out_chan_reg <= blk_chan_reg;
    end else if (grant_acc) begin
      out_valid_reg <= 1'b1;
      out_owner_blk_reg <= 1'b0;
      out_data_reg <= acc_fmt_data;
      out_chan_reg <= acc_chan_reg;
    end
  end
  // ====================
  // Block output engine
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_state_reg <= B_IDLE;
      blk_addr_reg <= 17'h0_0000;
      blk_end_reg <= 17'h0_0000;
      blk_chan_reg <= 3'h0;
      blk_back_reg <= 1'b0;
      blk_whole_reg <= 1'b0;
      blk_int_reg <= 1'b0;
      blk_word_reg <= 24'h00_0000;
    end else begin
      case (blk_state_reg)
        B_IDLE: begin
          if (accept && instr_op == `CIO_OP_BLKOUT && !sel_busy) begin
            blk_addr_reg <= instr_first_addr;
            blk_end_reg <= instr_end_addr;
            blk_chan_reg <= instr_channel_select;
            blk_back_reg <= instr_backward;
            blk_whole_reg <= instr_no_assembly;
            blk_int_reg <= instr_interrupt;
            // Empty block sends nothing
            if (instr_first_addr != instr_end_addr) begin
              blk_state_reg <= B_READ;
            end
          end
        end
        B_READ: begin
          if (mem_rd_ack) begin
            blk_word_reg <= mem_rd_data;
            blk_state_reg <= B_SEND1;
          end
        end
        B_SEND1: begin
          if (blk_sent) begin
            blk_state_reg <= blk_whole_reg ? B_STEP : B_SEND2;
          end
        end
        B_SEND2: begin
          if (blk_sent) begin
            blk_state_reg <= B_STEP;
          end
        end
        B_STEP: begin
          blk_addr_reg <= blk_addr_next;
          blk_state_reg <= (blk_addr_next == blk_end_reg) ? B_IDLE : B_READ;
        end
        default: blk_state_reg <= B_IDLE;
      endcase
    end
  end
  // ====================
  // Accumulator transfers and fetch control
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_state_reg <= A_IDLE;
      acc_chan_reg <= 3'h0;
      acc_char_reg <= 1'b0;
      acc_wide_reg <= 1'b0;
      acc_split_reg <= 1'b0;
      acc_fwd_reg <= 1'b0;
      acc_int_reg <= 1'b0;
      acc_word_reg <= 24'h00_0000;
      acc_load_valid <= 1'b0;
      acc_load_data <= 24'h00_0000;
      next_instruction_fetch <= 1'b0;
      next_fetch_plus3 <= 1'b0;
      xfer_interrupt <= 1'b0;
    end else begin
      acc_load_valid <= 1'b0;
      next_instruction_fetch <= 1'b0;
      xfer_interrupt <= blk_irq;
      case (acc_state_reg)
        A_IDLE: begin
          if (accept) begin
            acc_chan_reg <= instr_channel_select;
            acc_char_reg <= (instr_op == `CIO_OP_CHIN) || (instr_op == `CIO_OP_CHOUT);
            acc_wide_reg <= sel_wide;
            acc_int_reg <= instr_interrupt;
            acc_word_reg <= acc_in;
            acc_load_data <= 24'h00_0000;
            if (instr_op == `CIO_OP_WDIN) begin
              acc_split_reg <= sel_wide && (instr_mode == `CIO_MODE_ASM_FWD || instr_mode == `CIO_MODE_ASM_BWD);
              acc_fwd_reg <= (instr_mode == `CIO_MODE_ASM_FWD);
            end else begin
              acc_split_reg <= sel_wide && (instr_mode == `CIO_MODE_DIS_FWD || instr_mode == `CIO_MODE_DIS_BWD);
              acc_fwd_reg <= (instr_mode == `CIO_MODE_DIS_FWD);
            end
            if (sel_busy) begin
              next_instruction_fetch <= 1'b1;
              next_fetch_plus3 <= 1'b0;
            end else if (instr_op == `CIO_OP_BLKOUT) begin
              next_instruction_fetch <= 1'b1;
              next_fetch_plus3 <= 1'b1;
            end else if (instr_op == `CIO_OP_CHIN || instr_op == `CIO_OP_WDIN) begin
              acc_state_reg <= A_IN1;
            end else if (instr_op == `CIO_OP_CHOUT || instr_op == `CIO_OP_WDOUT) begin
              acc_state_reg <= A_OUT1;
            end else begin
              next_instruction_fetch <= 1'b1;
              next_fetch_plus3 <= 1'b0;
            end
          end
        end
        A_OUT1: begin
          if (acc_sent) begin
            if (acc_split_reg) begin
              acc_state_reg <= A_OUT2;
            end else begin
              acc_state_reg <= A_IDLE;
              next_instruction_fetch <= 1'b1;
              next_fetch_plus3 <= 1'b1;
              xfer_interrupt <= acc_int_reg;
            end
          end
        end
        A_OUT2: begin
          if (acc_sent) begin
            acc_state_reg <= A_IDLE;
            next_instruction_fetch <= 1'b1;
            next_fetch_plus3 <= 1'b1;
            xfer_interrupt <= acc_int_reg;
          end
        end
        A_IN1: begin
          if (in_take) begin
            if (acc_char_reg) begin
              acc_load_data <= {18'h0_0000, ch_in_data[5:0]};
            end else if (acc_split_reg) begin
              acc_load_data <= acc_fwd_reg ? {ch_in_data[11:0], 12'h000} : {12'h000, ch_in_data[11:0]};
            end else if (acc_wide_reg) begin
              acc_load_data <= ch_in_data;
            end else begin
              acc_load_data <= {12'h000, ch_in_data[11:0]};
            end
            if (acc_split_reg && !acc_char_reg) begin
              acc_state_reg <= A_IN2;
            end else begin
              acc_state_reg <= A_IDLE;
              acc_load_valid <= 1'b1;
              next_instruction_fetch <= 1'b1;
              next_fetch_plus3 <= 1'b1;
              xfer_interrupt <= acc_int_reg;
            end
          end
        end
        A_IN2: begin
          if (in_take) begin
            acc_load_data <= acc_fwd_reg ? {acc_load_data[23:12], ch_in_data[11:0]} :
              {ch_in_data[11:0], acc_load_data[11:0]};
            acc_state_reg <= A_IDLE;
            acc_load_valid <= 1'b1;
            next_instruction_fetch <= 1'b1;
            next_fetch_plus3 <= 1'b1;
            xfer_interrupt <= acc_int_reg;
          end
        end
        default: acc_state_reg <= A_IDLE;
      endcase
      // Both engines finishing together share one pulse, not lost to the accumulator flag
      if (blk_irq) xfer_interrupt <= 1'b1;
    end
  end
  // ====================
  // Register bus
  cio_axil_regs u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .status_word({27'h000_0000, blk_chan_reg, (acc_state_reg != A_IDLE), (blk_state_reg != B_IDLE)}),
    .curaddr_word({15'h0000, blk_addr_reg}),
    .ctrl_reg(ctrl_reg)
  );
endmodule

// *** cio_unit_asserts.sv ***
`timescale 1ns/10ps
`include "cio_consts.vh"
module cio_unit_asserts (
  // Clock, reset, issue
  input wire clk,
  input wire sys_rst,
  input wire instr_valid,
  input wire instr_ready,
  input wire [2:0] instr_op,
  input wire [2:0] instr_channel_select,
  input wire [7:0] chan_rw_active,
  input wire [7:0] chan_reply_pending,
  // Results
  input wire next_instruction_fetch,
  input wire next_fetch_plus3,
  input wire acc_load_valid,
  input wire [23:0] acc_load_data,
  input wire ch_out_valid,
  input wire [23:0] ch_out_data,
  input wire [2:0] ch_out_chan,
  input wire ch_out_ready
);
  // ====================
  // Last accepted instruction
  localparam logic [7:0] wide_m = `CIO_WIDE_MASK;
  logic [2:0] op_reg;
  logic [2:0] ch_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg <= 3'h0;
      ch_reg <= 3'h0;
    end else if (instr_valid && instr_ready) begin
      op_reg <= instr_op;
      ch_reg <= instr_channel_select;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence take_s;
    instr_valid && instr_ready;
  endsequence
  sequence busy_s;
    chan_rw_active[instr_channel_select] || chan_reply_pending[instr_channel_select];
  endsequence
  // ====================
  // Properties
  busy_fetch_a: assert property (
    take_s ##0 busy_s |=> next_instruction_fetch && !next_fetch_plus3)
    else $error("busy channel without short fetch");
  blk_fetch_a: assert property (
    take_s ##0 (instr_op == `CIO_OP_BLKOUT) |=> next_instruction_fetch)
    else $error("block op without fetch pulse");
  blk_free_a: assert property (
    take_s ##0 (instr_op == `CIO_OP_BLKOUT) |=> instr_ready)
    else $error("block op stalls issue");
  char_in_a: assert property (
    acc_load_valid && op_reg == `CIO_OP_CHIN |-> acc_load_data[23:6] == 18'h0_0000)
    else $error("char input upper bits set");
  word_in_a: assert property (
    acc_load_valid && op_reg == `CIO_OP_WDIN && !wide_m[ch_reg] |-> acc_load_data[23:12] == 12'h000)
    else $error("narrow word input upper half set");
  char_out_a: assert property (
    ch_out_valid && op_reg == `CIO_OP_CHOUT && ch_out_chan == ch_reg |-> ch_out_data[23:6] == 18'h0_0000)
    else $error("char output wider than six bits");
  narrow_out_a: assert property (
    ch_out_valid && !wide_m[ch_out_chan] |-> ch_out_data[23:12] == 12'h000)
    else $error("narrow channel got upper half");
  out_hold_a: assert property (
    ch_out_valid && !ch_out_ready |=> ch_out_valid && $stable(ch_out_data) && $stable(ch_out_chan))
    else $error("output item changed before taken");
endmodule

// *** cio_chan_model.sv ***
`timescale 1ns/10ps
module cio_chan_model (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Bench control
  input wire slow,
  input wire in_en,
  input wire [23:0] in_a,
  input wire [23:0] in_b,
  input wire [2:0] in_chan,
  // Channel side
  input wire ch_out_valid,
  output wire ch_out_ready,
  output logic ch_in_valid,
  output wire [23:0] ch_in_data,
  output wire [2:0] ch_in_chan,
  input wire ch_in_ready
);
  logic ptr;
  logic tick;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick <= 1'b0;
      ptr <= 1'b0;
      ch_in_valid <= 1'b0;
    end else begin
      tick <= ~tick;
      if (!in_en) begin
        ptr <= 1'b0;
        ch_in_valid <= 1'b0;
      end else if (ch_in_valid && ch_in_ready) begin
        ptr <= ~ptr;
        ch_in_valid <= !slow;
      end else begin
        ch_in_valid <= 1'b1;
      end
    end
  end
  // Slow mode stalls every other cycle
  assign ch_out_ready = !slow || tick;
  // Released line shows the inverse, never a stale match
  assign ch_in_data = ch_in_valid ? (ptr ? in_b : in_a) : ~(ptr ? in_b : in_a);
  assign ch_in_chan = in_chan;
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
`include "cio_consts.vh"
module testbench;
  typedef struct {logic [2:0] op, ch, md; logic [23:0] v, b, e0, e1; int n;} cio_row_t;
  logic clk = 0, sys_rst = 1, instr_valid = 0, instr_backward = 0, instr_no_assembly = 0, instr_interrupt = 0;
  logic mem_rd_ack = 0, slow = 0, in_en = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, last_p3;
  logic [2:0] instr_op = 0, instr_channel_select = 0, instr_mode = 0, in_chan = 0;
  logic [16:0] instr_first_addr = 0, instr_end_addr = 0;
  logic [23:0] acc_in = 0, mem_rd_data = 0, in_a = 0, in_b = 0, acc_got, w;
  logic [7:0] chan_rw_active = 0, chan_reply_pending = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rs;
  wire instr_ready, next_instruction_fetch, next_fetch_plus3, acc_load_valid, xfer_interrupt, mem_rd_req;
  wire ch_out_valid, ch_out_ready, ch_in_valid, ch_in_ready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [23:0] acc_load_data, ch_out_data, ch_in_data;
  wire [16:0] mem_rd_addr;
  wire [2:0] ch_out_chan, ch_in_chan;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [26:0] outq[$];
  int n_fetch = 0, n_int = 0, bad_count = 0, n_compared = 0, ni;
  cio_row_t rows[10] = '{
    '{`CIO_OP_CHIN, 1, 0, 24'hAB_CDE7, 0, 24'h00_0027, 0, 0},
    '{`CIO_OP_WDIN, 1, 1, 24'h12_3456, 0, 24'h00_0456, 0, 0},
    '{`CIO_OP_WDIN, 5, 0, 24'h11_1ABC, 24'h22_2DEF, 24'hAB_CDEF, 0, 0},
    '{`CIO_OP_WDIN, 5, 2, 24'h11_1ABC, 24'h22_2DEF, 24'hDE_FABC, 0, 0},
    '{`CIO_OP_WDIN, 5, 3, 24'h12_3456, 0, 24'h12_3456, 0, 0},
    '{`CIO_OP_CHOUT, 3, 0, 24'hFF_FFC5, 0, 24'h00_0005, 0, 1},
    '{`CIO_OP_WDOUT, 5, 2, 24'h87_6543, 0, 24'h00_0876, 24'h00_0543, 2},
    '{`CIO_OP_WDOUT, 5, 0, 24'h87_6543, 0, 24'h00_0543, 24'h00_0876, 2},
    '{`CIO_OP_WDOUT, 2, 1, 24'h87_6543, 0, 24'h00_0543, 0, 1},
    '{`CIO_OP_WDOUT, 6, 1, 24'h87_6543, 0, 24'h87_6543, 0, 1}};
  cio_unit i_dut (.*);
  cio_chan_model i_chan (.*);
  initial forever #4 clk = ~clk;
  // ====================
  // Storage model and monitor
  function automatic logic [23:0] wd(input logic [16:0] a);
    return {a[11:0], a[11:0] ^ 12'hA5C};
  endfunction
  always @(posedge clk) begin
    mem_rd_ack <= mem_rd_req && !mem_rd_ack;
    mem_rd_data <= wd(mem_rd_addr);
    if (ch_out_valid && ch_out_ready) outq.push_back({ch_out_chan, ch_out_data});
    if (next_instruction_fetch) begin
      n_fetch++;
      last_p3 = next_fetch_plus3;
    end
    if (xfer_interrupt) n_int++;
    if (acc_load_valid) acc_got = acc_load_data;
  end
  // ====================
  // Tasks
  task chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task run(input logic [2:0] op, ch, md, input logic [23:0] v, input logic [16:0] f, e, input logic bk, na, it);
    int k;
    k = n_fetch;
    last_p3 = 1'bx;
    instr_valid <= 1;
    instr_op <= op;
    instr_channel_select <= ch;
    instr_mode <= md;
    acc_in <= v;
    instr_first_addr <= f;
    instr_end_addr <= e;
    instr_backward <= bk;
    instr_no_assembly <= na;
    instr_interrupt <= it;
    do @(posedge clk); while (instr_ready !== 1'b1);
    instr_valid <= 0;
    for (int i = 0; i < 300 && n_fetch == k; i++) @(posedge clk);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask
  task axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // ====================
  // Sequence
  initial begin
    #200000;
    bad_count++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    axr(`CIO_REG_CTRL);
    chk(rd, `CIO_CTRL_RESET);
    axr(8'h0C);
    chk(rs, `CIO_RESP_SLVERR);
    foreach (rows[i]) begin
      in_a <= rows[i].v;
      in_b <= rows[i].b;
      in_chan <= rows[i].ch;
      in_en <= rows[i].n == 0;
      outq.delete();
      acc_got = 'x;
      ni = n_int;
      run(rows[i].op, rows[i].ch, rows[i].md, rows[i].v, 0, 0, 0, 0, 1);
      in_en <= 0;
      @(posedge clk);
      chk(last_p3, 1);
      chk(n_int - ni, 1);
      if (rows[i].n == 0) chk(acc_got, rows[i].e0);
      else chk(outq[0], {rows[i].ch, rows[i].e0});
      if (rows[i].n == 2) chk(outq[1], {rows[i].ch, rows[i].e1});
    end
    // Busy causes refuse the transfer
    chan_rw_active <= 8'h08;
    outq.delete();
    run(`CIO_OP_CHOUT, 3, 0, 0, 0, 0, 0, 0, 0);
    chk(last_p3, 0);
    chk(outq.size(), 0);
    chan_rw_active <= 0;
    chan_reply_pending <= 8'h20;
    run(`CIO_OP_BLKOUT, 5, 0, 0, 17'h10, 17'h12, 0, 0, 0);
    chk(last_p3, 0);
    chan_reply_pending <= 0;
    // Forward split block, stalling far side, input op alongside
    slow <= 1;
    ni = n_int;
    run(`CIO_OP_BLKOUT, 5, 0, 0, 17'h10, 17'h12, 0, 0, 1);
    chk(last_p3, 1);
    in_a <= 24'h00_0777;
    in_chan <= 1;
    in_en <= 1;
    run(`CIO_OP_WDIN, 1, 1, 0, 0, 0, 0, 0, 0);
    in_en <= 0;
    chk(acc_got, 24'h00_0777);
    for (int i = 0; i < 500 && n_int == ni; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk(outq.size(), 4);
    for (int k = 0; k < 4; k++) begin
      w = wd(17'(17'h10 + k / 2));
      chk(outq[k], {3'd5, 12'h000, k % 2 ? w[11:0] : w[23:12]});
    end
    chk(n_int - ni, 1);
    axr(`CIO_REG_CURADDR);
    chk(rd, 32'h0000_0012);
    // Backward whole words on a narrow channel
    slow <= 0;
    outq.delete();
    run(`CIO_OP_BLKOUT, 2, 0, 0, 17'h21, 17'h1F, 1, 1, 0);
    for (int i = 0; i < 500 && outq.size() < 2; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk(outq.size(), 2);
    for (int k = 0; k < 2; k++) begin
      w = wd(17'(17'h21 - k));
      chk(outq[k], {3'd2, 12'h000, w[11:0]});
    end
    // Disabled unit, then an empty block
    axw(`CIO_REG_CTRL, 32'h0000_0000);
    chk(rs, `CIO_RESP_OKAY);
    run(`CIO_OP_BLKOUT, 6, 0, 0, 17'h40, 17'h41, 0, 0, 0);
    chk(last_p3, 0);
    axw(`CIO_REG_CTRL, `CIO_CTRL_RESET);
    ni = n_int;
    run(`CIO_OP_BLKOUT, 4, 0, 0, 17'h30, 17'h30, 0, 0, 1);
    repeat (3) @(posedge clk);
    chk(n_int - ni, 1);
    chk(outq.size(), 2);
    close_out;
  end
endmodule
bind cio_unit cio_unit_asserts i_chk (.*);
